// [verilog/tla_defs.svh]
`ifndef TLA_DEFS_SVH
`define TLA_DEFS_SVH

// ==========================================
// Register offsets
`define TLA_OFS_ONE_SHOT   8'h0F
`define TLA_OFS_EXT_CRIT   8'h19
`define TLA_OFS_CH_MASK    8'h1F
`define TLA_OFS_INT_CRIT   8'h20
`define TLA_OFS_CRIT_HYST  8'h21
`define TLA_OFS_CONSEC     8'h22
`define TLA_OFS_GAIN_CFG   8'h25

// ==========================================
// Reset values
`define TLA_RST_CRIT       8'h55
`define TLA_RST_HYST       8'h0A
`define TLA_RST_CONSEC     8'h70
`define TLA_RST_GAIN_CFG   8'h08

// ==========================================
// Field positions
`define TLA_BIT_INT_MASK   0
`define TLA_BIT_EXT_MASK   1
`define TLA_BIT_TIMEOUT    7
`define TLA_CRIT_CNT_HI    6
`define TLA_CRIT_CNT_LO    4
`define TLA_ALRT_CNT_HI    3
`define TLA_ALRT_CNT_LO    1
`define TLA_BIT_GAIN_AUTO  3
`define TLA_GAIN_SEL_HI    2
`define TLA_GAIN_SEL_LO    0

// ==========================================
// Timing
`define TLA_TIMEOUT_MS     30
`define TLA_CLK_KHZ        125000

`endif

// [verilog/tla_pkg.sv]
package tla_pkg;

	// Bus slave states, Gray coded along idle, receive, ack, transmit, master ack
	typedef enum logic [2:0] {
		TLA_IDLE = 3'h0,
		TLA_RX   = 3'h1,
		TLA_ACK  = 3'h3,
		TLA_TX   = 3'h2,
		TLA_MACK = 3'h6
	} tla_bus_st_t;

endpackage : tla_pkg

// [verilog/tla_thermal_alarm.sv]
`timescale 1ns/1ps
`include "tla_defs.svh"
// Behaviour
// [R1] One-shot write in standby, idle starts conversion
// [R2] One-shot write while active is ignored
// [R3] Above critical limit asserts critical pin
// [R4] Critical pin unmaskable, released below limit minus hysteresis
// [R5] External mask blocks external alarms and faults
// [R6] Internal mask blocks internal alarms
// [R7] Channel masks never affect critical pin
// [R8] Consecutive faults increment channel alarm counter
// [R9] Clean measurement clears channel alarm counter
// [R10] Interrupt mode: count reached sets status, clears
// [R11] Comparator mode counts only high-limit excess
// [R12] Comparator alarm holds until below high minus hysteresis
// [R13] Optional bus timeout after long clock low
// [R14] Critical counter asserts critical pin at count
// [R15] Before assertion, below-limit clears critical counter
// [R16] After assertion, counter held until hysteresis point
// [R17] Shared three-bit alarm count field, default one
// [R18] Count codes decode one to four; reset 70h
// [R19] Auto gain compensation chosen each conversion start
// [R20] Compensation field reads setting; writes only when manual
// [R21] Codes 0-6 levels, 7 off, 8-F auto
// [R22] Host should program 111b for discrete diodes
// [R23] Comparator mode bit; ignores global mask
// [R24] Standby bit stops conversions
// [R25] Global mask blocks interrupt-mode alarm pin only
// [R26] Separate counters per channel, own measurements only
module tla_thermal_alarm #(
	parameter logic [6:0] DEV_ADDR    = 7'h2A,
	parameter int         TIMEOUT_CYC = `TLA_TIMEOUT_MS * `TLA_CLK_KHZ
) (
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output wire logic       sda_o,
	output wire logic       sda_oe_n,
	output wire logic       alert_o,
	output wire logic       alert_oe_n,
	output wire logic       therm_o,
	output wire logic       therm_oe_n,
	input  wire logic       cfg_mask_all,
	input  wire logic       cfg_standby,
	input  wire logic       cfg_comp_mode,
	input  wire logic       conv_busy,
	output wire logic       conv_start,
	input  wire logic       conv_begin,
	input  wire logic [2:0] beta_auto_in,
	output wire logic       beta_auto_en,
	output wire logic [2:0] beta_code,
	input  wire logic       meas_valid,
	input  wire logic       meas_chan,
	input  wire logic [7:0] meas_temp,
	input  wire logic [7:0] meas_high_lim,
	input  wire logic [7:0] meas_low_lim,
	input  wire logic       meas_fault,
	input  wire logic       stat_clear,
	output wire logic [1:0] stat_high,
	output wire logic [1:0] stat_low,
	output wire logic       stat_fault
);

	// ==========================================
	// Registers
	logic [7:0] ext_crit_q, int_crit_q, hyst_q, consec_q;
	logic [1:0] ch_mask_q;
	logic       gain_auto_q;
	logic [2:0] gain_sel_q;
	logic       conv_start_q;
	logic       alert_oe_n_q, therm_oe_n_q, sda_oe_n_q;

	// Bus slave state
	tla_pkg::tla_bus_st_t st_q;
	logic       scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
	logic [3:0] cnt_q;
	logic [7:0] sr_q, tx_q, ptr_q;
	logic       addr_ph_q, ptr_ph_q, rd_q, nack_q;
	logic [22:0] low_cnt_q;
	logic       scl_rise, scl_fall, bus_start, bus_stop, to_hit, wr_stb;
	logic [7:0] rd_data;

	// Channel results
	logic [1:0] cact_w, tact_w, pend_w, fire_w, sthi_w, stlo_w, stfl_w;
	logic [2:0] alrt_need, crit_need;

	// Count code decode: one plus number of ones gives 000=1, 001=2, 011=3, 111=4
	function automatic logic [2:0] tla_need(input logic [2:0] f);
		tla_need = {2'h0, f[0]} + {2'h0, f[1]} + {2'h0, f[2]} + 3'h1;
	endfunction : tla_need

	assign alrt_need = tla_need(consec_q[`TLA_ALRT_CNT_HI:`TLA_ALRT_CNT_LO]);   // see [R17] see [R18]
	assign crit_need = tla_need(consec_q[`TLA_CRIT_CNT_HI:`TLA_CRIT_CNT_LO]);   // see [R18]

	// ==========================================
	// Pin synchronisers, first stage feeds second only
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_s3 <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_s3 <= 1'b1;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
		end
	end

	assign scl_rise  = scl_s2 && !scl_s3;
	assign scl_fall  = !scl_s2 && scl_s3;
	assign bus_start = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
	assign bus_stop  = scl_s2 && scl_s3 && sda_s2 && !sda_s3;

	// Clock-low timer; saturates so a stuck line reports once
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			low_cnt_q <= 23'h0;
		end else if (scl_s2) begin
			low_cnt_q <= 23'h0;
		end else if (low_cnt_q != 23'(TIMEOUT_CYC)) begin
			low_cnt_q <= low_cnt_q + 23'h1;
		end
	end

	assign to_hit = consec_q[`TLA_BIT_TIMEOUT] && !scl_s2 && (low_cnt_q == 23'(TIMEOUT_CYC) - 23'h1);  // see [R13]

	// ==========================================
	// Read mux; unmapped offsets and the trigger read zero
	always_comb begin
		unique case (ptr_q)
			`TLA_OFS_EXT_CRIT:  rd_data = ext_crit_q;
			`TLA_OFS_CH_MASK:   rd_data = {6'h0, ch_mask_q};
			`TLA_OFS_INT_CRIT:  rd_data = int_crit_q;
			`TLA_OFS_CRIT_HYST: rd_data = hyst_q;
			`TLA_OFS_CONSEC:    rd_data = {consec_q[7:1], 1'b0};
			`TLA_OFS_GAIN_CFG:  rd_data = {4'h0, gain_auto_q, gain_sel_q};   // see [R20]
			default:            rd_data = 8'h00;
		endcase
	end

	assign wr_stb = scl_fall && (st_q == tla_pkg::TLA_RX) && (cnt_q == 4'h8) && !addr_ph_q && !ptr_ph_q;

	// ==========================================
	// Byte-level slave: address, pointer, data writes and reads
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q       <= tla_pkg::TLA_IDLE;
			cnt_q      <= 4'h0;
			sr_q       <= 8'h00;
			tx_q       <= 8'h00;
			ptr_q      <= 8'h00;
			addr_ph_q  <= 1'b0;
			ptr_ph_q   <= 1'b0;
			rd_q       <= 1'b0;
			nack_q     <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end else if (bus_stop || to_hit) begin   // see [R13]
			st_q       <= tla_pkg::TLA_IDLE;
			sda_oe_n_q <= 1'b1;
		end else if (bus_start) begin
			st_q       <= tla_pkg::TLA_RX;
			cnt_q      <= 4'h0;
			addr_ph_q  <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end else begin
			unique case (st_q)
				tla_pkg::TLA_IDLE: begin
					sda_oe_n_q <= 1'b1;
				end
				tla_pkg::TLA_RX: begin
					if (scl_rise) begin
						sr_q  <= {sr_q[6:0], sda_s2};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (addr_ph_q) begin
							if (sr_q[7:1] == DEV_ADDR) begin
								st_q       <= tla_pkg::TLA_ACK;
								rd_q       <= sr_q[0];
								ptr_ph_q   <= !sr_q[0];
								sda_oe_n_q <= 1'b0;
							end else begin
								st_q <= tla_pkg::TLA_IDLE;
							end
							addr_ph_q <= 1'b0;
						end else begin
							if (ptr_ph_q) begin
								ptr_q <= sr_q;
							end
							ptr_ph_q   <= 1'b0;
							st_q       <= tla_pkg::TLA_ACK;
							sda_oe_n_q <= 1'b0;
						end
					end
				end
				tla_pkg::TLA_ACK: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (rd_q) begin
							st_q       <= tla_pkg::TLA_TX;
							tx_q       <= {rd_data[6:0], 1'b0};
							sda_oe_n_q <= rd_data[7];
						end else begin
							st_q       <= tla_pkg::TLA_RX;
							sda_oe_n_q <= 1'b1;
						end
					end
				end
				tla_pkg::TLA_TX: begin
					if (scl_fall) begin
						if (cnt_q == 4'h7) begin
							st_q       <= tla_pkg::TLA_MACK;
							sda_oe_n_q <= 1'b1;
						end else begin
							cnt_q      <= cnt_q + 4'h1;
							tx_q       <= {tx_q[6:0], 1'b0};
							sda_oe_n_q <= tx_q[7];
						end
					end
				end
				tla_pkg::TLA_MACK: begin
					if (scl_rise) begin
						nack_q <= sda_s2;
					end else if (scl_fall) begin
						cnt_q <= 4'h0;
						if (nack_q) begin
							st_q <= tla_pkg::TLA_IDLE;
						end else begin
							st_q       <= tla_pkg::TLA_TX;
							tx_q       <= {rd_data[6:0], 1'b0};
							sda_oe_n_q <= rd_data[7];
						end
					end
				end
				default: begin
					st_q       <= tla_pkg::TLA_IDLE;
					sda_oe_n_q <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================
	// Register writes
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ext_crit_q <= `TLA_RST_CRIT;
			int_crit_q <= `TLA_RST_CRIT;
			hyst_q     <= `TLA_RST_HYST;
			consec_q   <= `TLA_RST_CONSEC;
			ch_mask_q  <= 2'h0;
		end else if (wr_stb) begin
			unique case (ptr_q)
				`TLA_OFS_EXT_CRIT:  ext_crit_q <= sr_q;
				`TLA_OFS_INT_CRIT:  int_crit_q <= sr_q;
				`TLA_OFS_CRIT_HYST: hyst_q     <= sr_q;
				`TLA_OFS_CONSEC:    consec_q   <= {sr_q[7:1], 1'b0};
				`TLA_OFS_CH_MASK:   ch_mask_q  <= sr_q[1:0];
				default:            ;
			endcase
		end
	end

	// One-shot only honoured in standby when the engine is idle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			conv_start_q <= 1'b0;
		end else begin
			conv_start_q <= wr_stb && (ptr_q == `TLA_OFS_ONE_SHOT) && cfg_standby && !conv_busy;  // see [R1] see [R2] see [R24]
		end
	end

	// Reset image of the gain register, sliced per field so no bits drop silently
	localparam logic [7:0] GAIN_RST = `TLA_RST_GAIN_CFG;

	// Gain compensation: auto mode loads the detector's pick at each conversion start
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gain_auto_q <= GAIN_RST[`TLA_BIT_GAIN_AUTO];
			gain_sel_q  <= GAIN_RST[`TLA_GAIN_SEL_HI:`TLA_GAIN_SEL_LO];
		end else if (wr_stb && ptr_q == `TLA_OFS_GAIN_CFG) begin
			gain_auto_q <= sr_q[`TLA_BIT_GAIN_AUTO];   // see [R21]
			if (!sr_q[`TLA_BIT_GAIN_AUTO]) begin
				gain_sel_q <= sr_q[`TLA_GAIN_SEL_HI:`TLA_GAIN_SEL_LO];   // see [R20]
			end
		end else if (conv_begin && gain_auto_q) begin
			gain_sel_q <= beta_auto_in;   // see [R19]
		end
	end

	// ==========================================
	// Per-channel counters: 0 internal, 1 external
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic [2:0] acnt_q, tcnt_q;
		logic       cact_q, tact_q, pend_q, sthi_q, stlo_q, stfl_q;
		logic       ev, over_hi, below_lo, flt, over_crit, crit_rel, hi_rel, cond;
		logic [7:0] crit;

		assign crit      = (i == 1) ? ext_crit_q : int_crit_q;
		assign ev        = meas_valid && (meas_chan == 1'(i));   // see [R26]
		assign over_hi   = meas_temp > meas_high_lim;
		assign below_lo  = meas_temp <= meas_low_lim;
		assign flt       = meas_fault && (i == 1);
		assign over_crit = meas_temp > crit;
		// Sum form avoids an underflow when hysteresis exceeds the limit
		assign crit_rel  = ({1'b0, meas_temp} + {1'b0, hyst_q}) < {1'b0, crit};
		assign hi_rel    = ({1'b0, meas_temp} + {1'b0, hyst_q}) < {1'b0, meas_high_lim};
		assign cond      = over_hi || below_lo || flt;
		assign fire_w[i] = ev && !cfg_comp_mode && cond && ((acnt_q + 3'h1) >= alrt_need);

		// Alarm counter in both pin modes
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				acnt_q <= 3'h0;
				cact_q <= 1'b0;
			end else if (ev) begin
				if (cfg_comp_mode) begin
					if (over_hi) begin   // see [R11]
						if (!cact_q) begin
							acnt_q <= acnt_q + 3'h1;
							cact_q <= (acnt_q + 3'h1) >= alrt_need;
						end
					end else if (!cact_q || hi_rel) begin   // see [R12]
						acnt_q <= 3'h0;
						cact_q <= 1'b0;
					end
				end else begin
					cact_q <= 1'b0;
					if (fire_w[i] || !cond) begin   // see [R9] see [R10]
						acnt_q <= 3'h0;
					end else begin
						acnt_q <= acnt_q + 3'h1;   // see [R8]
					end
				end
			end
		end

		// Status and pending alarm; a fire beats a same-cycle clear
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				pend_q <= 1'b0;
				sthi_q <= 1'b0;
				stlo_q <= 1'b0;
				stfl_q <= 1'b0;
			end else if (fire_w[i]) begin   // see [R10]
				pend_q <= pend_q || !ch_mask_q[i];   // see [R5] see [R6]
				sthi_q <= sthi_q || over_hi;
				stlo_q <= stlo_q || below_lo;
				stfl_q <= stfl_q || flt;
			end else if (stat_clear) begin
				pend_q <= 1'b0;
				sthi_q <= 1'b0;
				stlo_q <= 1'b0;
				stfl_q <= 1'b0;
			end
		end

		// Critical counter, held once asserted until the hysteresis point
		always_ff @(posedge ref_clk or negedge resetn) begin
			if (!resetn) begin
				tcnt_q <= 3'h0;
				tact_q <= 1'b0;
			end else if (ev) begin
				if (over_crit) begin
					if (!tact_q) begin
						tcnt_q <= tcnt_q + 3'h1;   // see [R14]
						tact_q <= (tcnt_q + 3'h1) >= crit_need;   // see [R3]
					end
				end else if (!tact_q || crit_rel) begin   // see [R15] see [R16] see [R4]
					tcnt_q <= 3'h0;
					tact_q <= 1'b0;
				end
			end
		end

		assign cact_w[i] = cact_q && !ch_mask_q[i];   // see [R5] see [R6]
		assign pend_w[i] = pend_q;
		assign tact_w[i] = tact_q;
		assign sthi_w[i] = sthi_q;
		assign stlo_w[i] = stlo_q;
		assign stfl_w[i] = stfl_q;
	end

	// ==========================================
	// Pins; comparator mode ignores the global mask, masks never touch the critical pin
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			alert_oe_n_q <= 1'b1;
			therm_oe_n_q <= 1'b1;
		end else begin
			alert_oe_n_q <= cfg_comp_mode ? !(|cact_w) : !((|pend_w) && !cfg_mask_all);  // see [R23] see [R25]
			therm_oe_n_q <= !(|tact_w);   // see [R7]
		end
	end

	assign sda_o        = 1'b0;
	assign sda_oe_n     = sda_oe_n_q;
	assign alert_o      = 1'b0;
	assign alert_oe_n   = alert_oe_n_q;
	assign therm_o      = 1'b0;
	assign therm_oe_n   = therm_oe_n_q;
	assign conv_start   = conv_start_q;
	assign beta_auto_en = gain_auto_q;
	assign beta_code    = gain_sel_q;
	assign stat_high    = sthi_w;
	assign stat_low     = stlo_w;
	assign stat_fault   = stfl_w[1];

	// ==========================================
	// Assertions
	property p_oneshot_go;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_stb && ptr_q == `TLA_OFS_ONE_SHOT && cfg_standby && !conv_busy) |=> conv_start;
	endproperty
	a_oneshot_go: assert property (p_oneshot_go) else $error("one-shot did not start"); // see [R1]

	property p_oneshot_active;
		@(posedge ref_clk) disable iff (!resetn)
		conv_start |-> $past(cfg_standby) && !$past(conv_busy);
	endproperty
	a_oneshot_active: assert property (p_oneshot_active) else $error("start while active"); // see [R2]

	property p_therm_pin;
		@(posedge ref_clk) disable iff (!resetn)
		(|tact_w) |=> !therm_oe_n;
	endproperty
	a_therm_pin: assert property (p_therm_pin) else $error("critical pin not driven"); // see [R7]

	property p_mask_all;
		@(posedge ref_clk) disable iff (!resetn)
		(!cfg_comp_mode && cfg_mask_all) |=> alert_oe_n;
	endproperty
	a_mask_all: assert property (p_mask_all) else $error("masked alarm drove pin"); // see [R25]

	property p_fire_ext;
		@(posedge ref_clk) disable iff (!resetn)
		(fire_w[1] && !ch_mask_q[1] && !cfg_mask_all && !cfg_comp_mode) |=> pend_w[1] ##1 (!alert_oe_n || cfg_mask_all);
	endproperty
	a_fire_ext: assert property (p_fire_ext) else $error("external fire not signalled"); // see [R10]

	property p_timeout;
		@(posedge ref_clk) disable iff (!resetn)
		to_hit |=> st_q == tla_pkg::TLA_IDLE && sda_oe_n;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not reset slave"); // see [R13]

	property p_gain_lock;
		@(posedge ref_clk) disable iff (!resetn)
		(wr_stb && ptr_q == `TLA_OFS_GAIN_CFG && sr_q[3] && !conv_begin) |=> $stable(beta_code);
	endproperty
	a_gain_lock: assert property (p_gain_lock) else $error("auto field changed by write"); // see [R20]

	property p_comp_pin;
		@(posedge ref_clk) disable iff (!resetn)
		(cfg_comp_mode && (|cact_w)) |=> !alert_oe_n;
	endproperty
	a_comp_pin: assert property (p_comp_pin) else $error("comparator alarm not on pin"); // see [R12]

endmodule : tla_thermal_alarm

// [verif/tla_smbus_host.sv]
`timescale 1ns/1ps
// ==========================================
// Bus host model: bit-banged, 80 ns clock period, open-drain data
module tla_smbus_host #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input  wire logic ref_clk,
	output logic      scl,
	output logic      sda_pull_n,
	input  wire logic sda_line
);
	// Bus clock stands high between frames
	initial begin
		scl = 1'h1;
		sda_pull_n = 1'h1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	// Data moves mid-low, so it never changes while the clock is high
	task automatic put_bit(input logic b);
		tick(2);
		sda_pull_n <= b;
		tick(3);
		scl <= 1'h1;
		tick(5);
		scl <= 1'h0;
	endtask : put_bit
	task automatic get_bit(output logic b);
		tick(2);
		sda_pull_n <= 1'h1;
		tick(3);
		scl <= 1'h1;
		tick(3);
		#1 b = sda_line;
		tick(2);
		scl <= 1'h0;
	endtask : get_bit
	// Also serves as a repeated start
	task automatic bus_start();
		tick(2);
		sda_pull_n <= 1'h1;
		tick(3);
		scl <= 1'h1;
		tick(5);
		sda_pull_n <= 1'h0;
		tick(5);
		scl <= 1'h0;
	endtask : bus_start
	task automatic bus_stop();
		tick(2);
		sda_pull_n <= 1'h0;
		tick(3);
		scl <= 1'h1;
		tick(5);
		sda_pull_n <= 1'h1;
		tick(5);
	endtask : bus_stop
	task automatic send(input logic [7:0] d, inout logic ok);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(a);
		ok = ok & (a === 1'h0);
	endtask : send
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
		ok = 1'h1;
		bus_start();
		send({ADDR, 1'h0}, ok);
		send(a, ok);
		send(d, ok);
		bus_stop();
	endtask : write_reg
	// Pointer write, repeated start, one byte read and refused
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		ok = 1'h1;
		bus_start();
		send({ADDR, 1'h0}, ok);
		send(a, ok);
		bus_start();
		send({ADDR, 1'h1}, ok);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(1'h1);
		bus_stop();
	endtask : read_reg
	// Stalls with the clock low where the device acknowledges, then reports the data line
	task automatic hold_addr(input int n, output logic level);
		logic [7:0] w;
		logic       a;
		w = {ADDR, 1'h0};
		bus_start();
		for (int i = 7; i >= 0; i--) put_bit(w[i]);
		tick(1);
		sda_pull_n <= 1'h1;
		tick(n);
		#1 level = sda_line;
		get_bit(a);
		bus_stop();
	endtask : hold_addr
endmodule : tla_smbus_host

// [verif/test_thermal_limit_alarm_logic.sv]
`timescale 1ns/1ps
module test_thermal_limit_alarm_logic;
	// ==========================================
	// Stimulus and observed signals
	logic       ref_clk = 1'h0;
	logic       resetn  = 1'h0;
	logic       cfg_mask_all, cfg_standby, cfg_comp_mode, conv_busy, conv_begin;
	logic       meas_valid, meas_chan, meas_fault, stat_clear;
	logic [2:0] beta_auto_in;
	logic [7:0] meas_temp, meas_high_lim, meas_low_lim;
	wire        scl, sda_pull_n, sda_line, sda_o, sda_oe_n, alert_o, alert_oe_n, therm_o, therm_oe_n;
	wire        conv_start, beta_auto_en, stat_fault;
	wire  [2:0] beta_code;
	wire  [1:0] stat_high, stat_low;
	int         mismatches = 0;
	int         tests_run  = 0;
	int         starts     = 0;

	always #4 ref_clk = ~ref_clk;
	// Open-drain data line with pull-up: low while either side pulls
	assign sda_line = sda_pull_n & (sda_oe_n | sda_o);
	// Conversion requests are counted, since each is a single-cycle pulse
	always @(posedge ref_clk) if (conv_start === 1'h1) starts <= starts + 1;

	// ==========================================
	// Instances; short bus timeout keeps the run brief
	tla_thermal_alarm #(.TIMEOUT_CYC(200)) tla_thermal_alarm_i (
		.ref_clk(ref_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .alert_o(alert_o), .alert_oe_n(alert_oe_n), .therm_o(therm_o),
		.therm_oe_n(therm_oe_n), .cfg_mask_all(cfg_mask_all), .cfg_standby(cfg_standby),
		.cfg_comp_mode(cfg_comp_mode), .conv_busy(conv_busy), .conv_start(conv_start),
		.conv_begin(conv_begin), .beta_auto_in(beta_auto_in), .beta_auto_en(beta_auto_en),
		.beta_code(beta_code), .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_temp(meas_temp),
		.meas_high_lim(meas_high_lim), .meas_low_lim(meas_low_lim), .meas_fault(meas_fault),
		.stat_clear(stat_clear), .stat_high(stat_high), .stat_low(stat_low), .stat_fault(stat_fault));
	tla_smbus_host tla_smbus_host_i (.ref_clk(ref_clk), .scl(scl), .sda_pull_n(sda_pull_n), .sda_line(sda_line));

	// ==========================================
	// Shared helpers
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'h1) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		tla_smbus_host_i.write_reg(a, d, ok);
		chk(ok, "write not acknowledged");
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		tla_smbus_host_i.read_reg(a, d, ok);
		chk(ok === 1'h1 && d === e, $sformatf("reg %h read %h", a, d));
	endtask : rd
	// Pins settle two edges after the measurement pulse
	task automatic meas(input logic ch, input logic [7:0] t, input logic [7:0] hi, input logic f);
		@(posedge ref_clk);
		meas_valid <= 1'h1;
		meas_chan <= ch;
		meas_temp <= t;
		meas_high_lim <= hi;
		meas_low_lim <= 8'h10;
		meas_fault <= f;
		@(posedge ref_clk);
		meas_valid <= 1'h0;
		meas_fault <= 1'h0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : meas
	task automatic pins(input logic a, input logic t, input string msg);
		chk(alert_oe_n === a && therm_oe_n === t && {alert_o, therm_o} === 2'h0, msg);
	endtask : pins
	task automatic clr();
		@(posedge ref_clk);
		stat_clear <= 1'h1;
		@(posedge ref_clk);
		stat_clear <= 1'h0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : clr
	task automatic beta(input logic [2:0] v);
		@(posedge ref_clk);
		conv_begin <= 1'h1;
		beta_auto_in <= v;
		@(posedge ref_clk);
		conv_begin <= 1'h0;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : beta

	// ==========================================
	// Scenarios
	task automatic t_regs();
		logic [7:0] ad [8] = '{8'h19, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h25, 8'h0F, 8'h30};
		logic [7:0] ex [8] = '{8'h55, 8'h00, 8'h55, 8'h0A, 8'h70, 8'h08, 8'h00, 8'h00};
		pins(1'h1, 1'h1, "pins after reset");
		chk(beta_auto_en === 1'h1 && beta_code === 3'h0 && starts == 0, "reset outputs");
		for (int i = 0; i < 8; i++) rd(ad[i], ex[i]);
		wr(8'h19, 8'hA3);
		rd(8'h19, 8'hA3);
		wr(8'h19, 8'h55);
	endtask : t_regs
	task automatic t_one_shot();
		cfg_standby <= 1'h1;
		wr(8'h0F, 8'hA5);
		chk(starts == 1, "one-shot in standby");
		conv_busy <= 1'h1;
		wr(8'h0F, 8'h01);
		cfg_standby <= 1'h0;
		conv_busy <= 1'h0;
		wr(8'h0F, 8'hFF);
		chk(starts == 1, "one-shot while busy or active");
	endtask : t_one_shot
	// Alarm count two, channels interleaved
	task automatic t_alarm_count();
		wr(8'h22, 8'h72);
		meas(1'h0, 8'h48, 8'h40, 1'h0);
		pins(1'h1, 1'h1, "alarm after one of two");
		meas(1'h1, 8'h48, 8'h40, 1'h0);
		meas(1'h0, 8'h48, 8'h40, 1'h0);
		pins(1'h0, 1'h1, "alarm after two");
		chk(stat_high === 2'h1, "high status");
		clr();
		pins(1'h1, 1'h1, "alarm after clear");
		meas(1'h1, 8'h30, 8'h40, 1'h0);
		meas(1'h1, 8'h48, 8'h40, 1'h0);
		pins(1'h1, 1'h1, "clean reading restarts count");
		meas(1'h0, 8'h10, 8'h40, 1'h0);
		meas(1'h0, 8'h10, 8'h40, 1'h0);
		chk(alert_oe_n === 1'h0 && stat_low === 2'h1, "low limit alarm");
		meas(1'h1, 8'h30, 8'h40, 1'h0);
		clr();
	endtask : t_alarm_count
	task automatic t_masks();
		wr(8'h22, 8'h70);
		wr(8'h1F, 8'h02);
		meas(1'h1, 8'h30, 8'h40, 1'h1);
		chk(alert_oe_n === 1'h1 && stat_fault === 1'h1, "masked ext fault");
		meas(1'h0, 8'h48, 8'h40, 1'h0);
		pins(1'h0, 1'h1, "int alarm with ext mask");
		clr();
		wr(8'h1F, 8'h01);
		meas(1'h0, 8'h48, 8'h40, 1'h0);
		chk(alert_oe_n === 1'h1 && stat_high[0] === 1'h1, "masked int high");
		meas(1'h1, 8'h48, 8'h40, 1'h0);
		pins(1'h0, 1'h1, "ext alarm with int mask");
		clr();
		wr(8'h1F, 8'h00);
		cfg_mask_all <= 1'h1;
		meas(1'h0, 8'h48, 8'h40, 1'h0);
		chk(alert_oe_n === 1'h1 && stat_high[0] === 1'h1, "global mask");
		cfg_mask_all <= 1'h0;
		meas(1'h0, 8'h30, 8'h40, 1'h0);
		meas(1'h1, 8'h30, 8'h40, 1'h0);
		clr();
	endtask : t_masks
	// Critical count four then one, both channel masks set
	task automatic t_critical();
		wr(8'h1F, 8'h03);
		repeat (3) meas(1'h1, 8'h60, 8'hF0, 1'h0);
		pins(1'h1, 1'h1, "critical after three");
		meas(1'h1, 8'h60, 8'hF0, 1'h0);
		pins(1'h1, 1'h0, "critical after four");
		meas(1'h1, 8'h50, 8'hF0, 1'h0);
		pins(1'h1, 1'h0, "critical inside hysteresis");
		meas(1'h1, 8'h4A, 8'hF0, 1'h0);
		pins(1'h1, 1'h1, "critical released");
		repeat (2) meas(1'h1, 8'h60, 8'hF0, 1'h0);
		meas(1'h1, 8'h55, 8'hF0, 1'h0);
		repeat (3) meas(1'h1, 8'h60, 8'hF0, 1'h0);
		pins(1'h1, 1'h1, "critical count restarted");
		meas(1'h1, 8'h40, 8'hF0, 1'h0);
		wr(8'h20, 8'h30);
		wr(8'h22, 8'h00);
		meas(1'h0, 8'h31, 8'hF0, 1'h0);
		pins(1'h1, 1'h0, "int critical count one");
		meas(1'h0, 8'h20, 8'hF0, 1'h0);
		pins(1'h1, 1'h1, "int critical released");
		wr(8'h20, 8'h55);
		wr(8'h1F, 8'h00);
	endtask : t_critical
	// Comparator mode, count three, global mask set
	task automatic t_comparator();
		cfg_comp_mode <= 1'h1;
		cfg_mask_all <= 1'h1;
		wr(8'h22, 8'h76);
		repeat (3) meas(1'h0, 8'h10, 8'h40, 1'h0);
		repeat (2) meas(1'h0, 8'h48, 8'h40, 1'h0);
		pins(1'h1, 1'h1, "comparator before count");
		meas(1'h0, 8'h48, 8'h40, 1'h0);
		pins(1'h0, 1'h1, "comparator at three");
		meas(1'h0, 8'h3A, 8'h40, 1'h0);
		pins(1'h0, 1'h1, "comparator held");
		meas(1'h0, 8'h30, 8'h40, 1'h0);
		pins(1'h1, 1'h1, "comparator released");
		cfg_comp_mode <= 1'h0;
		cfg_mask_all <= 1'h0;
		clr();
	endtask : t_comparator
	task automatic t_gain();
		beta(3'h5);
		rd(8'h25, 8'h0D);
		wr(8'h25, 8'h03);
		chk(beta_auto_en === 1'h0 && beta_code === 3'h3, "manual gain");
		wr(8'h25, 8'h07);
		beta(3'h2);
		rd(8'h25, 8'h07);
		wr(8'h25, 8'h0D);
		rd(8'h25, 8'h0F);
		beta(3'h2);
		chk(beta_auto_en === 1'h1 && beta_code === 3'h2, "auto gain");
	endtask : t_gain
	task automatic t_timeout();
		logic level;
		wr(8'h22, 8'hF0);
		tla_smbus_host_i.hold_addr(250, level);
		chk(level === 1'h1, "timeout releases data");
		wr(8'h22, 8'h70);
		tla_smbus_host_i.hold_addr(250, level);
		chk(level === 1'h0, "no timeout when off");
	endtask : t_timeout

	// ==========================================
	// Verdict and sequencing
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	initial begin
		{cfg_mask_all, cfg_standby, cfg_comp_mode, conv_busy, conv_begin} = 5'h00;
		{meas_valid, meas_chan, meas_fault, stat_clear} = 4'h0;
		beta_auto_in = 3'h0;
		{meas_temp, meas_high_lim, meas_low_lim} = 24'h000000;
		repeat (12) @(posedge ref_clk);
		resetn <= 1'h1;
		repeat (3) @(posedge ref_clk);
		#1;
		t_regs();
		t_one_shot();
		t_alarm_count();
		t_masks();
		t_critical();
		t_comparator();
		t_gain();
		t_timeout();
		final_report();
	end
	// About five times the expected run length
	initial begin
		repeat (60000) @(posedge ref_clk);
		mismatches++;
		final_report();
	end
endmodule : test_thermal_limit_alarm_logic
